// File: core/als_pkg.sv
package als_pkg;

  // Timing base
  localparam int CLK_PERIOD_NS   = 25;
  localparam int ALERT_PULSE_NS  = 1000;
  localparam int ALERT_PULSE_CYC = (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AR_RESET_US     = 500;
  localparam int AR_RESET_CYC    = (AR_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC        = 16;

  // Counter widths
  localparam int CNT_W   = 15;
  localparam int PULSE_W = 6;
  localparam int RUN_W   = 4;

  // Measurement and threshold layout
  localparam int MANT_W = 20;
  localparam int EXP_W  = 4;
  localparam int THR_W  = 12;
  localparam int CODE_W = 36;
  localparam logic [4:0] THR_BASE_SHIFT = 5'h08;

  // Measurement mode codes
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_FORCED  = 2'h1;
  localparam logic [1:0] MODE_REGULAR = 2'h2;
  localparam logic [1:0] MODE_CONT    = 2'h3;

  // Alert pin function codes
  localparam logic [1:0] ALERT_FN_THRESH = 2'h0;
  localparam logic [1:0] ALERT_FN_EOC    = 2'h1;
  localparam logic [1:0] ALERT_FN_FIFO   = 2'h3;

  // Range code that enables auto-range
  localparam logic [3:0] RANGE_AUTO = 4'hC;

  // Result FIFO slot count minus one
  localparam logic [1:0] FIFO_LAST = 2'h3;

  // Reset values
  localparam logic [1:0] MODE_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAKE,
    ST_ARRESET,
    ST_CONV
  } seq_state_e;

endpackage : als_pkg

// File: core/als_mode_alert.sv
// Function
// - Mode 0: standby, no conversions
// - Mode 3: back-to-back conversions, stay powered
// - Mode 1: auto-range reset, 500 us, each trigger
// - Mode 2: keep auto-range history between triggers
// - One-shot: standby, convert once, standby again
// - Direction 0: pin edge triggers, no completion output
// - Write 1/2 triggers; mode clears after completion
// - Direction 1: pin may signal one-shot completion
// - Triggers ignored while a conversion runs
// - Fast wakeup keeps circuits powered between triggers
// - Open-drain pin, level set by polarity
// - Latch selects transparent or latched scheme
// - Transparent pin: on above, off below, hold
// - Transparent flags set/clear per limit, hold between
// - Latched flags and pin held until flag read
// - Changes need 2^fault-count consecutive faults (1, 2, 4 or 8)
// - Function 1: 1 us pulse per conversion
// - Function 3: 1 us pulse every four conversions
// - Flags follow latch scheme whatever pin function
// - Threshold shifted by eight plus exponent
// - Outside either threshold counts as fault
// - Range code 0xC enables auto-range
`timescale 1ns/1ps
`default_nettype none

module als_mode_alert #(
  parameter int unsigned AR_RESET_CYCLES = als_pkg::AR_RESET_CYC,
  parameter int unsigned WAKE_CYCLES     = als_pkg::WAKE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      linkClk,
  input  wire logic                      linkRst,
  input  wire logic                      modeWrite,
  input  wire logic [1:0]                modeWrData,
  input  wire logic                      flagRead,
  input  wire logic                      latchMode,
  input  wire logic [1:0]                faultCount,
  input  wire logic [1:0]                alertFunction,
  input  wire logic                      alert_polarity,
  input  wire logic                      alertDir,
  input  wire logic                      fast_wakeup,
  input  wire logic [3:0]                rangeSel,
  input  wire logic [als_pkg::THR_W-1:0]  thrHigh,
  input  wire logic [als_pkg::EXP_W-1:0]  thrHighExp,
  input  wire logic [als_pkg::THR_W-1:0]  thrLow,
  input  wire logic [als_pkg::EXP_W-1:0]  thrLowExp,
  input  wire logic                      convDone,
  input  wire logic [als_pkg::MANT_W-1:0] measMant,
  input  wire logic [als_pkg::EXP_W-1:0]  measExp,
  input  wire logic                      alertPinI,
  output logic                           alertPinO,
  output logic                           alertPinOe,
  output logic                           convStart,
  output logic                           autoRangeReset,
  output logic                           autoRangeEn,
  output logic                           analogPower,
  output logic [1:0]                     modeValue,
  output logic                           flagHigh,
  output logic                           flagLow,
  output logic [als_pkg::MANT_W-1:0]      resultMant,
  output logic [als_pkg::EXP_W-1:0]       resultExp,
  output logic                           resultNew
);

  typedef struct packed {
    logic       modeTog;
    logic [1:0] modeData;
    logic       flagTog;
  } link_s;

  typedef struct packed {
    als_pkg::seq_state_e        st;
    logic [als_pkg::CNT_W-1:0]   cnt;
    logic [1:0]                 mode;
    logic                       regTrig;
    logic                       pwr;
    logic                       arEn;
    logic                       convStart;
    logic                       arReset;
    logic                       pinS1;
    logic                       pinS2;
    logic                       pinS3;
    logic                       mTg1;
    logic                       mTg2;
    logic                       mTg3;
    logic                       fTg1;
    logic                       fTg2;
    logic                       fTg3;
    logic [als_pkg::RUN_W-1:0]   hiRun;
    logic [als_pkg::RUN_W-1:0]   loRun;
    logic                       flagH;
    logic                       flagL;
    logic                       thrAlert;
    logic [1:0]                 fifoCnt;
    logic                       pulseReq;
    logic [als_pkg::PULSE_W-1:0] pulseCnt;
    logic [als_pkg::MANT_W-1:0]  resMant;
    logic [als_pkg::EXP_W-1:0]   resExp;
    logic                       resNew;
    logic                       alertOe;
  } core_s;

  link_s lk_q;
  link_s lk_d;
  core_s q;
  core_s d;

  logic                       modeEv;
  logic                       flagEv;
  logic                       pinAsserted;
  logic                       pinWasAsserted;
  logic                       hwTrigEv;
  logic                       regTrigEv;
  logic                       oneShotMode;
  logic                       faultHi;
  logic                       faultLo;
  logic [als_pkg::RUN_W-1:0]   need;
  logic [als_pkg::RUN_W-1:0]   hiRunN;
  logic [als_pkg::RUN_W-1:0]   loRunN;
  logic                       qualHi;
  logic                       qualLo;
  logic                       pulseOn;
  logic                       alertActive;
  logic [als_pkg::CODE_W-1:0]  measCode;
  logic [als_pkg::CODE_W-1:0]  thrHiCode;
  logic [als_pkg::CODE_W-1:0]  thrLoCode;

  // Link side: host writes and flag reads become toggles
  always_comb begin
    lk_d = lk_q;
    if (modeWrite) begin
      lk_d.modeTog  = ~lk_q.modeTog;
      lk_d.modeData = modeWrData;
    end
    if (flagRead) begin
      lk_d.flagTog = ~lk_q.flagTog;
    end
  end

  // Link side registers
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // Events after the crossing; only the second and third stages are read
  assign modeEv         = q.mTg2 ^ q.mTg3;
  assign flagEv         = q.fTg2 ^ q.fTg3;
  assign pinAsserted    = alert_polarity ? q.pinS2 : ~q.pinS2;
  assign pinWasAsserted = alert_polarity ? q.pinS3 : ~q.pinS3;
  assign oneShotMode    = (q.mode == als_pkg::MODE_FORCED) || (q.mode == als_pkg::MODE_REGULAR);
  assign hwTrigEv       = ~alertDir & oneShotMode & pinAsserted & ~pinWasAsserted;
  assign regTrigEv      = modeEv && ((lk_q.modeData == als_pkg::MODE_FORCED) ||
                                     (lk_q.modeData == als_pkg::MODE_REGULAR));

  // Linear codes for threshold comparison
  assign measCode  = als_pkg::CODE_W'(measMant) << measExp;
  assign thrHiCode = als_pkg::CODE_W'(thrHigh) << (als_pkg::THR_BASE_SHIFT + {1'b0, thrHighExp});
  assign thrLoCode = als_pkg::CODE_W'(thrLow) << (als_pkg::THR_BASE_SHIFT + {1'b0, thrLowExp});
  assign faultHi   = measCode > thrHiCode;
  assign faultLo   = measCode < thrLoCode;

  // Consecutive fault runs, saturating
  assign need   = als_pkg::RUN_W'(1) << faultCount;
  assign hiRunN = faultHi ? ((q.hiRun >= need) ? need : q.hiRun + 4'h1) : 4'h0;
  assign loRunN = faultLo ? ((q.loRun >= need) ? need : q.loRun + 4'h1) : 4'h0;
  assign qualHi = faultHi && (hiRunN >= need);
  assign qualLo = faultLo && (loRunN >= need);

  assign pulseOn = q.pulseCnt != '0;
  // Pin function: threshold state or conversion pulse
  always_comb begin
    if (alertFunction == als_pkg::ALERT_FN_THRESH) begin
      alertActive = latchMode ? (q.flagH | q.flagL) : q.thrAlert;
    end else begin
      alertActive = pulseOn;
    end
  end

  // Sequencer, thresholds and alert
  always_comb begin
    d           = q;
    d.convStart = 1'b0;
    d.arReset   = 1'b0;
    d.resNew    = 1'b0;
    d.pulseReq  = 1'b0;
    d.pinS1     = alertPinI;
    d.pinS2     = q.pinS1;
    d.pinS3     = q.pinS2;
    d.mTg1      = lk_q.modeTog;
    d.mTg2      = q.mTg1;
    d.mTg3      = q.mTg2;
    d.fTg1      = lk_q.flagTog;
    d.fTg2      = q.fTg1;
    d.fTg3      = q.fTg2;
    d.arEn      = rangeSel == als_pkg::RANGE_AUTO;
    if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (q.pulseCnt != '0) begin
      d.pulseCnt = q.pulseCnt - 1'b1;
    end
    if (q.pulseReq) begin
      d.pulseCnt = als_pkg::PULSE_W'(als_pkg::ALERT_PULSE_CYC);
    end
    // Latched flags clear on a flag read; a set below wins
    if (flagEv && latchMode) begin
      d.flagH = 1'b0;
      d.flagL = 1'b0;
    end
    case (q.st)
      als_pkg::ST_OFF: begin
        if ((modeEv && lk_q.modeData == als_pkg::MODE_CONT) || regTrigEv || hwTrigEv) begin
          d.st      = als_pkg::ST_WAKE;
          d.regTrig = regTrigEv;
          d.cnt     = q.pwr ? '0 : als_pkg::CNT_W'(WAKE_CYCLES - 1);
        end
      end
      als_pkg::ST_WAKE: begin
        if (q.cnt == '0) begin
          if (q.mode == als_pkg::MODE_FORCED && q.arEn) begin
            d.st      = als_pkg::ST_ARRESET;
            d.arReset = 1'b1;
            d.cnt     = als_pkg::CNT_W'(AR_RESET_CYCLES - 1);
          end else begin
            d.st        = als_pkg::ST_CONV;
            d.convStart = 1'b1;
          end
        end
      end
      als_pkg::ST_ARRESET: begin
        if (q.cnt == '0) begin
          d.st        = als_pkg::ST_CONV;
          d.convStart = 1'b1;
        end
      end
      als_pkg::ST_CONV: begin
        // Triggers are not looked at here
        if (convDone) begin
          d.resMant = measMant;
          d.resExp  = measExp;
          d.resNew  = 1'b1;
          d.fifoCnt = q.fifoCnt + 2'h1;
          d.pulseReq = (alertFunction == als_pkg::ALERT_FN_EOC) ||
                       (alertFunction == als_pkg::ALERT_FN_FIFO && q.fifoCnt == als_pkg::FIFO_LAST);
          d.hiRun = hiRunN;
          d.loRun = loRunN;
          if (latchMode) begin
            if (qualHi) begin
              d.flagH = 1'b1;
            end
            if (qualLo) begin
              d.flagL = 1'b1;
            end
          end else if (qualHi) begin
            d.flagH    = 1'b1;
            d.flagL    = 1'b0;
            d.thrAlert = 1'b1;
          end else if (qualLo) begin
            d.flagH    = 1'b0;
            d.flagL    = 1'b1;
            d.thrAlert = 1'b0;
          end
          if (q.mode == als_pkg::MODE_CONT) begin
            d.convStart = 1'b1;
          end else begin
            d.st = als_pkg::ST_OFF;
            if (q.regTrig) begin
              d.mode    = als_pkg::MODE_OFF;
              d.regTrig = 1'b0;
            end
          end
        end
      end
      default: begin
        d.st = als_pkg::ST_OFF;
      end
    endcase
    // A host write wins over the completion clear
    if (modeEv) begin
      d.mode = lk_q.modeData;
      if (lk_q.modeData == als_pkg::MODE_OFF) begin
        d.st        = als_pkg::ST_OFF;
        d.regTrig   = 1'b0;
        d.convStart = 1'b0;
        d.arReset   = 1'b0;
      end
    end
    d.pwr = (d.st != als_pkg::ST_OFF) || (d.mode == als_pkg::MODE_CONT) ||
            (fast_wakeup && ((d.mode == als_pkg::MODE_FORCED) || (d.mode == als_pkg::MODE_REGULAR)));
    d.alertOe = alertDir & (alertActive ^ alert_polarity);
  end

  // Core registers
  always_ff @(posedge clk) begin
    if (rst) begin
      q      <= '0;
      q.st   <= als_pkg::ST_OFF;
      q.mode <= als_pkg::MODE_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign alertPinO      = 1'b0;
  assign alertPinOe     = q.alertOe;
  assign convStart      = q.convStart;
  assign autoRangeReset = q.arReset;
  assign autoRangeEn    = q.arEn;
  assign analogPower    = q.pwr;
  assign modeValue      = q.mode;
  assign flagHigh       = q.flagH;
  assign flagLow        = q.flagL;
  assign resultMant     = q.resMant;
  assign resultExp      = q.resExp;
  assign resultNew      = q.resNew;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_pulseBody;
    pulseOn [*8] ##32 pulseOn ##1 !pulseOn;
  endsequence

  property p_standby;
    (q.st == als_pkg::ST_OFF && q.mode == als_pkg::MODE_OFF) |-> !q.convStart && !q.pwr;
  endproperty
  a_standby: assert property (p_standby) else $error("conversion activity in standby");

  property p_contRestart;
    (q.st == als_pkg::ST_CONV && convDone && q.mode == als_pkg::MODE_CONT && !modeEv)
      |=> q.convStart && q.st == als_pkg::ST_CONV && q.pwr;
  endproperty
  a_contRestart: assert property (p_contRestart) else $error("continuous mode did not restart");

  property p_forcedReset;
    $rose(q.st == als_pkg::ST_ARRESET) |-> q.arReset && q.mode == als_pkg::MODE_FORCED;
  endproperty
  a_forcedReset: assert property (p_forcedReset) else $error("auto-range reset outside forced mode");

  property p_oneShotEnd;
    (q.st == als_pkg::ST_CONV && convDone && q.mode != als_pkg::MODE_CONT) |=> q.st == als_pkg::ST_OFF;
  endproperty
  a_oneShotEnd: assert property (p_oneShotEnd) else $error("one-shot did not return to standby");

  property p_inputNoDrive;
    $past(!alertDir) |-> !alertPinOe;
  endproperty
  a_inputNoDrive: assert property (p_inputNoDrive) else $error("alert pin driven while an input");

  property p_regClear;
    (q.st == als_pkg::ST_CONV && convDone && q.regTrig && q.mode != als_pkg::MODE_CONT && !modeEv)
      |=> q.mode == als_pkg::MODE_OFF;
  endproperty
  a_regClear: assert property (p_regClear) else $error("mode not cleared after one-shot");

  property p_busyIgnore;
    (q.st == als_pkg::ST_CONV && !convDone && !modeEv) |=> q.st == als_pkg::ST_CONV && !q.convStart;
  endproperty
  a_busyIgnore: assert property (p_busyIgnore) else $error("trigger accepted while converting");

  property p_pulseWidth;
    $rose(pulseOn) |-> s_pulseBody;
  endproperty
  a_pulseWidth: assert property (p_pulseWidth) else $error("alert pulse is not forty cycles");

  property p_pulseAfterResult;
    $rose(pulseOn) |-> $past(q.resNew);
  endproperty
  a_pulseAfterResult: assert property (p_pulseAfterResult) else $error("pulse before result stored");

  property p_latchHold;
    (latchMode && q.flagH && !flagEv) |=> q.flagH;
  endproperty
  a_latchHold: assert property (p_latchHold) else $error("latched flag dropped without read");

  property p_transparentHigh;
    (q.st == als_pkg::ST_CONV && convDone && !latchMode && qualHi) |=> q.flagH && !q.flagL && q.thrAlert;
  endproperty
  a_transparentHigh: assert property (p_transparentHigh) else $error("above-limit flags wrong");

  property p_faultRun;
    (q.st == als_pkg::ST_CONV && convDone && !faultHi) |=> q.hiRun == '0;
  endproperty
  a_faultRun: assert property (p_faultRun) else $error("fault run not restarted");

endmodule : als_mode_alert

`default_nettype wire

// File: tb/als_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module als_host_model (
  input  wire logic       linkClk,
  output logic            modeWrite,
  output logic [1:0]      modeWrData,
  output logic            flagRead
);
  // Idle levels before the first transaction
  initial begin
    modeWrite  = 1'b0;
    modeWrData = 2'h0;
    flagRead   = 1'b0;
  end

  // One-cycle mode write, data held, then spacing
  task automatic writeMode(input logic [1:0] value);
    @(posedge linkClk);
    modeWrite  <= 1'b1;
    modeWrData <= value;
    @(posedge linkClk);
    modeWrite <= 1'b0;
    repeat (24) @(posedge linkClk);
  endtask : writeMode

  // One-cycle read of the flag register
  task automatic readFlags();
    @(posedge linkClk);
    flagRead <= 1'b1;
    @(posedge linkClk);
    flagRead <= 1'b0;
    repeat (24) @(posedge linkClk);
  endtask : readFlags
endmodule : als_host_model

`default_nettype wire

// File: tb/test_light_sensor_mode_and_alert_logic.sv
`timescale 1ns/1ps
`default_nettype none

module test_light_sensor_mode_and_alert_logic;
  localparam int AR = 20;
  logic        clk = 1'b0, linkClk = 1'b0, rst = 1'b1, linkRst = 1'b1;
  logic        modeWrite, flagRead, latchMode, polarity, alertDir, convDone;
  logic [1:0]  modeWrData, faultCount, alertFunction;
  logic [3:0]  rangeSel, measExp, resultExp;
  logic [19:0] measMant, resultMant;
  logic        alertPinO, alertPinOe, convStart, autoRangeReset, autoRangeEn;
  logic        analogPower, flagHigh, flagLow, resultNew, pinLevel, lastOe, fastWake, pinPull;
  logic [1:0]  modeValue;
  int          n_checks, n_mismatch, starts, dones, pulses, run, lastLen, arResets, arCyc, arGap, p0, s0;
  logic [19:0] tm [3] = '{20'h0_1000, 20'h0_1800, 20'h0_0100};
  logic [3:0]  te [3] = '{4'h2, 4'h0, 4'h0};
  int          seq [13] = '{0, 0, 0, 1, 0, 0, 0, 0, 1, 2, 2, 2, 2};
  logic [0:12] expH = 13'b0000_0001_1111_0;
  logic [0:12] expL = 13'b0000_0000_0000_1;

  // Clocks, unrelated in phase
  always #12.5 clk = ~clk;
  always #6 linkClk = ~linkClk;

  // Open-drain pin with pull-up; the bench may also pull it low
  assign pinLevel = (alertPinOe === 1'b1 || pinPull === 1'b1) ? 1'b0 : 1'b1;

  als_host_model host_u (
    .linkClk    (linkClk),
    .modeWrite  (modeWrite),
    .modeWrData (modeWrData),
    .flagRead   (flagRead)
  );

  als_mode_alert #(.AR_RESET_CYCLES(AR), .WAKE_CYCLES(2)) dut_u (
    .clk            (clk),
    .rst            (rst),
    .linkClk        (linkClk),
    .linkRst        (linkRst),
    .modeWrite      (modeWrite),
    .modeWrData     (modeWrData),
    .flagRead       (flagRead),
    .latchMode      (latchMode),
    .faultCount     (faultCount),
    .alertFunction  (alertFunction),
    .alert_polarity (polarity),
    .alertDir       (alertDir),
    .fast_wakeup    (fastWake),
    .rangeSel       (rangeSel),
    .thrHigh        (12'h010),
    .thrHighExp     (4'h1),
    .thrLow         (12'h008),
    .thrLowExp      (4'h0),
    .convDone       (convDone),
    .measMant       (measMant),
    .measExp        (measExp),
    .alertPinI      (pinLevel),
    .alertPinO      (alertPinO),
    .alertPinOe     (alertPinOe),
    .convStart      (convStart),
    .autoRangeReset (autoRangeReset),
    .autoRangeEn    (autoRangeEn),
    .analogPower    (analogPower),
    .modeValue      (modeValue),
    .flagHigh       (flagHigh),
    .flagLow        (flagLow),
    .resultMant     (resultMant),
    .resultExp      (resultExp),
    .resultNew      (resultNew)
  );

  // Event counters: starts, auto-range gap, pin pulses
  always @(posedge clk) begin
    if (autoRangeReset === 1'b1) begin
      arResets++;
      arCyc = 0;
    end else arCyc++;
    if (convStart === 1'b1) begin
      starts++;
      arGap = arCyc;
    end
    if (alertPinOe === 1'b1) begin
      if (!lastOe) begin
        pulses++;
        run = 0;
      end
      run++;
    end else if (lastOe) lastLen = run;
    lastOe = (alertPinOe === 1'b1);
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Bounded wait: 0 for a fresh start, 1 for a new result
  task automatic waitOn(input int which);
    int i;
    for (i = 0; i < 400; i++) begin
      #1;
      if (which == 0 && starts > dones) break;
      if (which == 1 && resultNew === 1'b1) break;
      @(posedge clk);
    end
    if (i == 400) begin
      check(1'b0, 1'b1);
      wrap_up();
    end
  endtask : waitOn

  // Converter stand-in: answer a start with one result
  task automatic conv(input int k);
    waitOn(0);
    repeat (50) @(posedge clk);
    convDone <= 1'b1;
    measMant <= tm[k];
    measExp  <= te[k];
    dones++;
    @(posedge clk);
    convDone <= 1'b0;
    waitOn(1);
    check(resultMant, tm[k]);
    check(resultExp, te[k]);
  endtask : conv

  // Main sequence
  initial begin
    {convDone, measMant, measExp, latchMode, faultCount, polarity, rangeSel, lastOe, fastWake, pinPull} = '0;
    {n_checks, n_mismatch, starts, dones, pulses, run, lastLen, arResets, arCyc, arGap} = '0;
    alertFunction = als_pkg::ALERT_FN_EOC;
    alertDir = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    linkRst <= 1'b0;
    tick(30);
    check(modeValue, als_pkg::MODE_RESET);
    check(analogPower, 1'b0);
    check(starts, 0);
    host_u.writeMode(als_pkg::MODE_REGULAR);
    p0 = pulses;
    conv(1);
    check(pulses, p0);
    tick(5);
    check(modeValue, als_pkg::MODE_OFF);
    check(analogPower, 1'b0);
    check(autoRangeEn, 1'b0);
    tick(50);
    check(pulses - p0, 1);
    check(lastLen, als_pkg::ALERT_PULSE_CYC);
    @(posedge clk);
    rangeSel <= als_pkg::RANGE_AUTO;
    host_u.writeMode(als_pkg::MODE_FORCED);
    conv(1);
    check(arResets, 1);
    check(arGap >= AR && arGap <= AR + 8, 1'b1);
    check(autoRangeEn, 1'b1);
    host_u.writeMode(als_pkg::MODE_REGULAR);
    waitOn(0);
    host_u.writeMode(als_pkg::MODE_REGULAR);
    conv(1);
    tick(80);
    check(starts, dones);
    check(arResets, 1);
    @(posedge clk);
    alertDir <= 1'b0;
    p0 = pulses;
    host_u.writeMode(als_pkg::MODE_REGULAR);
    conv(1);
    tick(60);
    check(pulses, p0);
    @(posedge clk);
    alertDir <= 1'b1;
    alertFunction <= als_pkg::ALERT_FN_FIFO;
    p0 = pulses;
    s0 = starts;
    host_u.writeMode(als_pkg::MODE_CONT);
    repeat (8) conv(1);
    tick(50);
    check(analogPower, 1'b1);
    check(starts - s0, 9);
    check(pulses - p0, 2);
    @(posedge clk);
    alertFunction <= als_pkg::ALERT_FN_THRESH;
    faultCount <= 2'h2;
    // Fault run broken once, then rise and fall
    for (int k = 0; k < 13; k++) begin
      conv(seq[k]);
      check(flagHigh, expH[k]);
      check(flagLow, expL[k]);
      tick(3);
      check(alertPinOe, expH[k]);
    end
    @(posedge clk);
    polarity <= 1'b1;
    tick(3);
    check(alertPinOe, 1'b1);
    check(alertPinO, 1'b0);
    @(posedge clk);
    polarity <= 1'b0;
    latchMode <= 1'b1;
    faultCount <= 2'h0;
    host_u.readFlags();
    tick(2);
    check(flagLow, 1'b0);
    conv(0);
    tick(3);
    check(alertPinOe, 1'b1);
    conv(1);
    check(flagHigh, 1'b1);
    conv(2);
    check(flagHigh, 1'b1);
    check(flagLow, 1'b1);
    host_u.readFlags();
    tick(2);
    check({flagHigh, flagLow, alertPinOe}, 3'h0);
    // Mode 2 stored mid-conversion, then a pin edge triggers
    @(posedge clk);
    fastWake <= 1'b1;
    host_u.writeMode(als_pkg::MODE_REGULAR);
    conv(1);
    tick(2);
    check(modeValue, als_pkg::MODE_REGULAR);
    check(analogPower, 1'b1);
    @(posedge clk);
    alertDir <= 1'b0;
    pinPull  <= 1'b1;
    conv(1);
    check(modeValue, als_pkg::MODE_REGULAR);
    check(analogPower, 1'b1);
    @(posedge clk);
    pinPull  <= 1'b0;
    fastWake <= 1'b0;
    tick(3);
    check(analogPower, 1'b0);
    host_u.writeMode(als_pkg::MODE_OFF);
    tick(20);
    check(analogPower, 1'b0);
    s0 = starts;
    tick(60);
    check(starts, s0);
    wrap_up();
  end
endmodule : test_light_sensor_mode_and_alert_logic

`default_nettype wire
